// [logic/url_link_ctrl.sv]
// Link control and status for the USB side of a Type-C redriving switch.
// Assumes an I2C target front end hands over decoded byte writes and reads;
// pins arrive asynchronous, strap levels come pre-decoded as three-level codes.
// Functional notes
// - Bit 7 reads back compliance state, read-only, zero after reset.
// - Bit 6 zero forces zero equalization during LFPS; one applies settings.
// - Bit 5 set requires LFPS held 200us before leaving U2/U3.
// - Bit 4 zero allows receiver detect in U2/U3; one suppresses it.
// - Bits 3:2 pick downstream detect period: 8, 12, 48, 96 ms.
// - Bits 1:0 pick auto, downstream forced, upstream forced, or compliance off.
// - Upper pin low, lower pin high selects USB only.
// - Both configuration pins high selects USB plus two display lanes.
// - Upper pin high, lower pin low selects four display lanes.
// - Both address straps floating gives target address 0x12.
// - Each receiver equalization is independently settable by register.
// - Override zero shows strap levels; override one lets writes set equalization.
module url_link_ctrl
	import url_pkg::*;
(
	// Clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RESET_I,
	// Register access from the I2C target
	input  wire logic       REG_WR_I,
	input  wire logic [7:0] REG_ADDR_I,
	input  wire logic [7:0] REG_WDATA_I,
	output logic      [7:0] REG_RDATA_O,
	// Configuration and strap pins
	input  wire logic       CONFIG_SELECT_HI_I,
	input  wire logic       CONFIG_SELECT_LO_I,
	input  wire logic       FLIP_I,
	input  wire logic [1:0] DISPLAY_EQ_ADDR_HI_STRAP_I,
	input  wire logic [1:0] UPSTREAM_EQ_ADDR_LO_STRAP_I,
	input  wire logic [1:0] RX_EQ_STRAP_I,
	// Link state from the analog front end
	input  wire logic       LFPS_DETECT_I,
	input  wire logic       LOW_POWER_I,
	input  wire logic       FSM_COMPLIANCE_I,
	// Controls to the datapath
	output logic      [6:0] I2C_ADDR_O,
	output logic      [3:0] RX1_EQ_O,
	output logic      [3:0] RX2_EQ_O,
	output logic      [3:0] UP_EQ_O,
	output logic            LOW_POWER_EXIT_O,
	output logic            RX_DETECT_PULSE_O,
	output logic      [3:0] CONFIG_O,
	output logic            FLIP_O,
	output logic            COMPLIANCE_DOWN_O,
	output logic            COMPLIANCE_UP_O
);

	// ==========================================================
	// Pin synchronisers
	logic cfg_hi_s, cfg_lo_s, flip_s, lfps_s;

	url_sync u_sync_hi   (.clk_i(REF_CLK_I), .rst_i(RESET_I), .d_i(CONFIG_SELECT_HI_I), .q_o(cfg_hi_s));
	url_sync u_sync_lo   (.clk_i(REF_CLK_I), .rst_i(RESET_I), .d_i(CONFIG_SELECT_LO_I), .q_o(cfg_lo_s));
	url_sync u_sync_flip (.clk_i(REF_CLK_I), .rst_i(RESET_I), .d_i(FLIP_I), .q_o(flip_s));
	url_sync u_sync_lfps (.clk_i(REF_CLK_I), .rst_i(RESET_I), .d_i(LFPS_DETECT_I), .q_o(lfps_s));

	// ==========================================================
	// Registers
	logic [6:0] ctrl_q;       // Writable bits 6:0 of the link register
	logic       eq_ovr_q;     // eq_software_override
	logic [3:0] rx1_eq_q, rx2_eq_q, up_eq_q;
	logic       cmp_active_q;
	logic       straps_taken_q;

	wire apply_a                 = ctrl_q[BIT_APPLY_A];
	wire low_power_exit_debounce = ctrl_q[BIT_DEBOUNCE];
	wire sleep_rx_detect_off     = ctrl_q[BIT_SLEEP_DET];
	wire [1:0] downstream_detect_period = ctrl_q[BIT_PERIOD_LO +: 2];
	wire [1:0] compliance_force_select  = ctrl_q[BIT_FORCE_LO +: 2];

	// Register writes; bit 7 of the link register is status so is never written
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			ctrl_q   <= RST_LINK_CTRL[6:0];
			eq_ovr_q <= 1'b0;
		end
		else if (REG_WR_I && REG_ADDR_I == ADDR_LINK_CTRL)
			ctrl_q <= REG_WDATA_I[6:0];
		else if (REG_WR_I && REG_ADDR_I == ADDR_EQ_CTRL)
			eq_ovr_q <= REG_WDATA_I[0];
	end

	// Straps caught once, at the first edge after release; both floating give the base
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			straps_taken_q <= 1'b0;
			I2C_ADDR_O     <= I2C_ADDR_FLOAT;
		end
		else if (!straps_taken_q)
		begin
			straps_taken_q <= 1'b1;
			I2C_ADDR_O     <= I2C_ADDR_FLOAT + {3'h0, DISPLAY_EQ_ADDR_HI_STRAP_I, UPSTREAM_EQ_ADDR_LO_STRAP_I}
				- {3'h0, STRAP_FLOAT, STRAP_FLOAT};
		end
	end

	// Equalization fields: strap mirror or software value
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			rx1_eq_q <= 4'h0;
			rx2_eq_q <= 4'h0;
			up_eq_q  <= 4'h0;
		end
		else if (!eq_ovr_q)
		begin
			rx1_eq_q <= {2'h0, RX_EQ_STRAP_I};
			rx2_eq_q <= {2'h0, RX_EQ_STRAP_I};
			up_eq_q  <= {2'h0, UPSTREAM_EQ_ADDR_LO_STRAP_I};
		end
		else if (REG_WR_I && REG_ADDR_I == ADDR_RX_EQ)
		begin
			rx1_eq_q <= REG_WDATA_I[3:0];
			rx2_eq_q <= REG_WDATA_I[7:4];
		end
		else if (REG_WR_I && REG_ADDR_I == ADDR_UP_EQ)
			up_eq_q <= REG_WDATA_I[3:0];
	end

	// Applied equalization: zero during LFPS unless apply_a is set
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I || (lfps_s && !apply_a))
		begin
			RX1_EQ_O <= 4'h0;
			RX2_EQ_O <= 4'h0;
			UP_EQ_O  <= 4'h0;
		end
		else
		begin
			RX1_EQ_O <= rx1_eq_q;
			RX2_EQ_O <= rx2_eq_q;
			UP_EQ_O  <= up_eq_q;
		end
	end

	// ==========================================================
	// Low-power exit debounce
	logic [TMR_W-1:0] deb_cnt_q;

	// Count LFPS persistence; any gap restarts the wait
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I || !lfps_s || !LOW_POWER_I)
			deb_cnt_q <= '0;
		else if (deb_cnt_q != TMR_W'(DEBOUNCE_CYC))
			deb_cnt_q <= deb_cnt_q + 1'b1;
	end

	// Exit request; without debounce the first LFPS cycle suffices
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			LOW_POWER_EXIT_O <= 1'b0;
		else
			LOW_POWER_EXIT_O <= LOW_POWER_I && lfps_s
				&& (!low_power_exit_debounce || deb_cnt_q == TMR_W'(DEBOUNCE_CYC - 1)
				|| deb_cnt_q == TMR_W'(DEBOUNCE_CYC));
	end

	// ==========================================================
	// Receiver detect timer
	logic [TMR_W-1:0] det_cnt_q;
	logic [TMR_W-1:0] det_period;

	// Period select
	always_comb
	begin
		unique case (downstream_detect_period)
			2'h0:    det_period = TMR_W'(DETECT_8_CYC);
			2'h1:    det_period = TMR_W'(DETECT_12_CYC);
			2'h2:    det_period = TMR_W'(DETECT_48_CYC);
			default: det_period = TMR_W'(DETECT_96_CYC);
		endcase
	end

	// Free-running interval; a period change takes effect at once, wrapping at the next edge if the count is past the new end
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I || det_cnt_q >= det_period - 1'b1)
			det_cnt_q <= '0;
		else
			det_cnt_q <= det_cnt_q + 1'b1;
	end

	// Detect strobe, suppressed in U2/U3 when asked
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			RX_DETECT_PULSE_O <= 1'b0;
		else
			RX_DETECT_PULSE_O <= (det_cnt_q >= det_period - 1'b1)
				&& !(LOW_POWER_I && sleep_rx_detect_off);
	end

	// ==========================================================
	// Compliance control
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			cmp_active_q      <= 1'b0;
			COMPLIANCE_DOWN_O <= 1'b0;
			COMPLIANCE_UP_O   <= 1'b0;
		end
		else
		begin
			unique case (compliance_force_select)
				CMP_AUTO: cmp_active_q <= FSM_COMPLIANCE_I;
				CMP_DOWN: cmp_active_q <= 1'b1;
				CMP_UP:   cmp_active_q <= 1'b1;
				default:  cmp_active_q <= 1'b0;
			endcase
			COMPLIANCE_DOWN_O <= compliance_force_select == CMP_DOWN;
			COMPLIANCE_UP_O   <= compliance_force_select == CMP_UP;
		end
	end

	// ==========================================================
	// Configuration from pins; flip applies in every mode
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			CONFIG_O <= CFG_OFF;
			FLIP_O   <= 1'b0;
		end
		else
		begin
			unique case ({cfg_hi_s, cfg_lo_s})
				2'b01:   CONFIG_O <= CFG_USB;
				2'b11:   CONFIG_O <= CFG_USB_DP2;
				2'b10:   CONFIG_O <= CFG_DP4;
				default: CONFIG_O <= CFG_OFF;
			endcase
			FLIP_O <= flip_s;
		end
	end

	// ==========================================================
	// Read mux; status bit 7 is live compliance state
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			REG_RDATA_O <= RST_ZERO;
		else
			unique case (REG_ADDR_I)
				ADDR_RX_EQ:     REG_RDATA_O <= {rx2_eq_q, rx1_eq_q};
				ADDR_UP_EQ:     REG_RDATA_O <= {4'h0, up_eq_q};
				ADDR_LINK_CTRL: REG_RDATA_O <= {cmp_active_q, ctrl_q};
				ADDR_EQ_CTRL:   REG_RDATA_O <= {7'h00, eq_ovr_q};
				default:        REG_RDATA_O <= RST_ZERO;
			endcase
	end

	// ==========================================================
	// Checks
	a_status_reset: assert property (@(posedge REF_CLK_I) $past(RESET_I) |-> !cmp_active_q)
		else $error("compliance status not clear after reset");
	a_lfps_zero_eq: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(lfps_s && !apply_a) |=> (RX1_EQ_O == 4'h0 && UP_EQ_O == 4'h0))
		else $error("equalization not zeroed during LFPS");
	a_debounce_wait: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(low_power_exit_debounce && $rose(lfps_s) && LOW_POWER_I) |=> !LOW_POWER_EXIT_O [*8])
		else $error("low-power exit before debounce");
	a_sleep_detect: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(LOW_POWER_I && sleep_rx_detect_off) |=> !RX_DETECT_PULSE_O)
		else $error("detect in U2/U3 while suppressed");
	a_force_down: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(compliance_force_select == CMP_DOWN) |=> (COMPLIANCE_DOWN_O && cmp_active_q))
		else $error("downstream compliance not forced");
	a_cfg_usb: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(!cfg_hi_s && cfg_lo_s) |=> CONFIG_O == CFG_USB)
		else $error("USB-only configuration missed");
	a_cfg_dp2: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(cfg_hi_s && cfg_lo_s) |=> CONFIG_O == CFG_USB_DP2)
		else $error("two-lane configuration missed");
	a_cfg_dp4: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		(cfg_hi_s && !cfg_lo_s) |=> CONFIG_O == CFG_DP4)
		else $error("four-lane configuration missed");
	a_override_hold: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		!eq_ovr_q |=> rx1_eq_q == {2'h0, $past(RX_EQ_STRAP_I)})
		else $error("equalization field not mirroring strap");
	c_detect: cover property (@(posedge REF_CLK_I) RX_DETECT_PULSE_O);
	c_exit: cover property (@(posedge REF_CLK_I) LOW_POWER_EXIT_O && low_power_exit_debounce);
	c_dp2: cover property (@(posedge REF_CLK_I) CONFIG_O == CFG_USB_DP2 && FLIP_O);

endmodule : url_link_ctrl

// [logic/url_pkg.sv]
// Package for the USB link control block: register map, field positions,
// reset values, timing constants and mode enumerations.
// Assumes a 20 MHz reference clock.
package url_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned DEBOUNCE_US      = 200;
	localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned DETECT_8_MS      = 8;
	localparam int unsigned DETECT_12_MS     = 12;
	localparam int unsigned DETECT_48_MS     = 48;
	localparam int unsigned DETECT_96_MS     = 96;
	localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
	localparam int unsigned DETECT_8_CYC     = DETECT_8_MS * CYC_PER_MS;
	localparam int unsigned DETECT_12_CYC    = DETECT_12_MS * CYC_PER_MS;
	localparam int unsigned DETECT_48_CYC    = DETECT_48_MS * CYC_PER_MS;
	localparam int unsigned DETECT_96_CYC    = DETECT_96_MS * CYC_PER_MS;
	localparam int unsigned TMR_W            = 22;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_RX_EQ        = 8'h20;
	localparam logic [7:0] ADDR_UP_EQ        = 8'h21;
	localparam logic [7:0] ADDR_LINK_CTRL    = 8'h22;
	localparam logic [7:0] ADDR_EQ_CTRL      = 8'h23;
	localparam logic [7:0] RST_LINK_CTRL     = 8'h04;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [6:0] I2C_ADDR_FLOAT    = 7'h12;

	// Field positions in the link control register
	localparam int unsigned BIT_COMPLIANCE   = 7;
	localparam int unsigned BIT_APPLY_A      = 6;
	localparam int unsigned BIT_DEBOUNCE     = 5;
	localparam int unsigned BIT_SLEEP_DET    = 4;
	localparam int unsigned BIT_PERIOD_LO    = 2;
	localparam int unsigned BIT_FORCE_LO     = 0;

	// ==========================================================
	// Strap level encoding
	typedef enum logic [1:0]
	{
		STRAP_LOW   = 2'h0,
		STRAP_FLOAT = 2'h1,
		STRAP_HIGH  = 2'h2
	} url_strap_t;

	// Operating configuration, one-hot
	typedef enum logic [3:0]
	{
		CFG_OFF     = 4'h1,
		CFG_USB     = 4'h2,
		CFG_USB_DP2 = 4'h4,
		CFG_DP4     = 4'h8
	} url_cfg_t;

	// Compliance forcing selections
	localparam logic [1:0] CMP_AUTO          = 2'h0;
	localparam logic [1:0] CMP_DOWN          = 2'h1;
	localparam logic [1:0] CMP_UP            = 2'h2;
	localparam logic [1:0] CMP_OFF           = 2'h3;

endpackage : url_pkg

// [logic/url_sync.sv]
// Two-flop synchroniser for one asynchronous pin.
// Assumes the input comes from outside the clock domain.
module url_sync
	import url_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Data
	input  wire logic d_i,
	output logic      q_o
);

	// ==========================================================
	// Synchroniser
	logic meta_q;

	// First flop feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end
		else
		begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule : url_sync

// [tb/url_pd_model.sv]
// Model of the PD controller that drives the register port and the address straps.
// Assumes the bench calls its tasks; outputs change only at falling clock edges.
module url_pd_model
	import url_pkg::*;
(
	// Clock
	input  wire logic       clk_i,
	// Register access
	output logic            wr_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	input  wire logic [7:0] rdata_i,
	// Address straps
	output logic      [1:0] strap_hi_o,
	output logic      [1:0] strap_lo_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Straps settle from time zero, before any access
	initial
	begin
		strap_hi_o = STRAP_FLOAT;
		strap_lo_o = STRAP_FLOAT;
		wr_o       = 1'b0;
		addr_o     = ADDR_LINK_CTRL;
		wdata_o    = 8'h00;
	end

	// One-cycle write strobe per byte
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o  = a;
		wdata_o = d;
		wr_o    = 1'b1;
		@(negedge clk_i);
		wr_o    = 1'b0;
	endtask : write

	// Read data is registered, so wait two edges after the address
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		@(negedge clk_i);
		@(negedge clk_i);
		d = rdata_i;
	endtask : read

	// New strap levels; the address takes them at the next reset release, the upstream mirror whenever override is off
	task automatic set_straps(input logic [1:0] hi, input logic [1:0] lo);
		@(negedge clk_i);
		strap_hi_o = hi;
		strap_lo_o = lo;
	endtask : set_straps

endmodule : url_pd_model

// [tb/usb_redriver_link_control_bench.sv]
// Self-checking bench for the link control block.
// Assumes a 20 MHz clock; inputs driven at falling edges.
module usb_redriver_link_control_bench
	import url_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       rst;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [1:0] s_hi;
	logic [1:0] s_lo;
	logic       cfg_hi;
	logic       cfg_lo;
	logic       flip;
	logic       lfps;
	logic       low_pw;
	logic       fsm_cmp;
	logic [6:0] i2c_addr;
	logic [3:0] rx1;
	logic [3:0] rx2;
	logic       pw_exit;
	logic [3:0] cfg;
	logic       flip_q;
	logic       c_down;
	logic       c_up;
	logic [7:0] rd;
	logic [7:0] rd0;
	logic [1:0] rx_strap;
	logic [3:0] up_eq;
	logic       det;
	logic       det_seen = 1'b0;
	logic [3:0] cfg_exp [4] = '{4'h1, 4'h2, 4'h8, 4'h4};
	int         errors;
	int         comparisons;
	int         cycles;

	// ==========================================================
	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	url_pd_model pd_u (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata),
		.strap_hi_o(s_hi), .strap_lo_o(s_lo));

	url_link_ctrl dut_u (.REF_CLK_I(clk), .RESET_I(rst), .REG_WR_I(wr), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .CONFIG_SELECT_HI_I(cfg_hi), .CONFIG_SELECT_LO_I(cfg_lo),
		.FLIP_I(flip), .DISPLAY_EQ_ADDR_HI_STRAP_I(s_hi), .UPSTREAM_EQ_ADDR_LO_STRAP_I(s_lo),
		.RX_EQ_STRAP_I(rx_strap), .LFPS_DETECT_I(lfps), .LOW_POWER_I(low_pw),
		.FSM_COMPLIANCE_I(fsm_cmp), .I2C_ADDR_O(i2c_addr), .RX1_EQ_O(rx1), .RX2_EQ_O(rx2),
		.UP_EQ_O(up_eq), .LOW_POWER_EXIT_O(pw_exit), .RX_DETECT_PULSE_O(det), .CONFIG_O(cfg),
		.FLIP_O(flip_q), .COMPLIANCE_DOWN_O(c_down), .COMPLIANCE_UP_O(c_up));

	// ==========================================================
	// Compare and report
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// Timeout: the tests need well under this many cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			conclude();
		end
	end

	// Detect strobes, looked at mid-cycle while the registered pulse stands
	always @(negedge clk)
	begin
		if (det === 1'b1)
			det_seen = 1'b1;
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		rst     = 1'b1;
		cfg_hi  = 1'b0;
		cfg_lo  = 1'b0;
		flip    = 1'b0;
		lfps    = 1'b0;
		low_pw  = 1'b0;
		fsm_cmp = 1'b1;
		rx_strap = STRAP_FLOAT;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check({1'b0, i2c_addr}, 8'h12);
		pd_u.read(ADDR_LINK_CTRL, rd);
		check(rd & 8'h7f, RST_LINK_CTRL);
		// Every compliance selection; bit 7 written high must be ignored
		for (int s = 0; s < 4; s++)
		begin
			pd_u.write(ADDR_LINK_CTRL, 8'h84 | 8'(s));
			pd_u.read(ADDR_LINK_CTRL, rd);
			check(rd, {(s != 3), 7'h04 | 7'(s)});
			check({6'h0, c_down, c_up}, {6'h0, (s == 1), (s == 2)});
		end
		fsm_cmp = 1'b0;
		pd_u.write(ADDR_LINK_CTRL, 8'h04);
		pd_u.read(ADDR_LINK_CTRL, rd);
		check(rd, 8'h04);
		// Every pin combination, flip toggled alongside
		for (int i = 0; i < 4; i++)
		begin
			{cfg_hi, cfg_lo} = 2'(i);
			flip = i[0];
			repeat (6) @(negedge clk);
			check({4'h0, cfg}, {4'h0, cfg_exp[i]});
			check({7'h0, flip_q}, {7'h0, i[0]});
		end
		// Override off: writes do not change the strap mirror
		pd_u.read(ADDR_RX_EQ, rd0);
		check(rd0, {2'h0, STRAP_FLOAT, 2'h0, STRAP_FLOAT});
		pd_u.write(ADDR_RX_EQ, 8'h5a);
		pd_u.read(ADDR_RX_EQ, rd);
		check(rd, {2'h0, STRAP_FLOAT, 2'h0, STRAP_FLOAT});
		pd_u.write(ADDR_EQ_CTRL, 8'h01);
		pd_u.write(ADDR_RX_EQ, 8'h5a);
		pd_u.write(ADDR_UP_EQ, 8'h0c);
		pd_u.read(ADDR_RX_EQ, rd);
		check(rd, 8'h5a);
		pd_u.read(ADDR_UP_EQ, rd);
		check(rd, 8'h0c);
		check({rx2, rx1}, 8'h5a);
		check({4'h0, up_eq}, 8'h0c);
		// LFPS in U2/U3, no debounce, zero equalization during LFPS
		low_pw = 1'b1;
		lfps   = 1'b1;
		repeat (6) @(negedge clk);
		check({4'h0, rx1}, 8'h00);
		check({4'h0, up_eq}, 8'h00);
		check({7'h0, pw_exit}, 8'h01);
		lfps = 1'b0;
		// Debounce on, settings applied during LFPS
		// Detect also suppressed in U2/U3 until the second reset
		pd_u.write(ADDR_LINK_CTRL, 8'h74);
		pd_u.read(ADDR_LINK_CTRL, rd);
		check(rd, 8'h74);
		repeat (4) @(negedge clk);
		lfps = 1'b1;
		repeat (3000) @(negedge clk);
		check({7'h0, pw_exit}, 8'h00);
		check({4'h0, rx1}, 8'h0a);
		check({4'h0, up_eq}, 8'h0c);
		repeat (1010) @(negedge clk);
		check({7'h0, pw_exit}, 8'h01);
		// Second reset with new straps: address and strap mirrors follow them
		lfps     = 1'b0;
		low_pw   = 1'b0;
		rx_strap = STRAP_HIGH;
		pd_u.set_straps(STRAP_HIGH, STRAP_LOW);
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check({1'b0, i2c_addr}, 8'h15);
		pd_u.read(ADDR_RX_EQ, rd);
		check(rd, {2'h0, STRAP_HIGH, 2'h0, STRAP_HIGH});
		pd_u.read(ADDR_UP_EQ, rd);
		check(rd, {6'h00, STRAP_LOW});
		pd_u.read(ADDR_LINK_CTRL, rd);
		check(rd, RST_LINK_CTRL);
		// First detect is due 12 ms after a reset, well beyond this run
		check({7'h0, det_seen}, 8'h00);
		conclude();
	end

endmodule : usb_redriver_link_control_bench
